// file: xcvr_flags_params.svh
`ifndef XCVR_FLAGS_PARAMS_SVH
`define XCVR_FLAGS_PARAMS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFS_LINE_FLAG      8'h00
`define OFS_XCVR_STATUS    8'h04
`define OFS_XCVR_CONTROL   8'h08
`define OFS_XCVR_MODE      8'h0C
`define OFS_RX_TX_DATA     8'h10
`define OFS_ERROR_CODE     8'h14
`define OFS_PROTO_CONFIG   8'h18

// ****************************************************************
// field positions
// ****************************************************************
`define BIT_RX_SOURCE_SELECT  5
`define BIT_SOFT_RESET        7
`define BIT_LOOPBACK          2
`define BIT_TURNAROUND        4

// ****************************************************************
// index of each sticky flag in the flag bank
// ****************************************************************
`define FLG_POLL        0
`define FLG_POLL_ACK    1
`define FLG_AUTO_RESP   2
`define FLG_BYTE_ERR    3
`define FLG_TURNAROUND  4
`define FLG_RX_FULL     5
`define FLG_WORD_READY  6
`define FLG_IN_FRAME    7
`define FLG_RX_FAULT    8
`define FLG_COUNT       9

// ****************************************************************
// reset values, counts and answers
// ****************************************************************
`define RST_TX_QUEUE_EMPTY  1'h1
`define LINE_QUIET_CYCLES   5'h10
`define RX_QUEUE_FULL_WORDS 2'h3
`define ALL_STATIONS_ADDR   3'h7
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`endif

// file: xcvr_flags_pkg.sv
`default_nettype none

package xcvr_flags_pkg;

	typedef enum logic [1:0] {
		MODE_COAX     = 2'b00,
		MODE_REPEATER = 2'b01,
		MODE_TWINAX   = 2'b10,
		MODE_OCTET    = 2'b11
	} proto_mode_type;

	typedef enum logic {
		WR_COLLECT = 1'b0,
		WR_RESPOND = 1'b1
	} wr_state_type;

endpackage

`default_nettype wire

// file: flag_cell.sv
`timescale 1ns/10ps
`default_nettype none

module flag_cell (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic soft_rst_i,
	input  wire logic set_i,
	input  wire logic clr_i,
	output logic      flag_o
);

	typedef struct packed {
		logic flag;
	} cell_state_type;

	cell_state_type state;
	cell_state_type next_state;

	// soft reset dominates; otherwise a set in the clearing cycle is kept
	always_comb begin
		next_state = state;
		if (soft_rst_i) begin
			next_state.flag = 1'h0;
		end else if (set_i) begin
			next_state.flag = 1'h1;
		end else if (clr_i) begin
			next_state.flag = 1'h0;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign flag_o = state.flag;

endmodule

`default_nettype wire

// file: line_activity_detect.sv
`timescale 1ns/10ps
`default_nettype none
`include "xcvr_flags_params.svh"

module line_activity_detect (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic soft_rst_i,
	input  wire logic line_i,
	output logic      active_o
);

	typedef struct packed {
		logic       prev;
		logic [4:0] quiet;
		logic       active;
	} act_state_type;

	act_state_type state;
	act_state_type next_state;

	always_comb begin
		next_state = state;
		next_state.prev = line_i;
		if (soft_rst_i) begin
			next_state.active = 1'h0;
			next_state.quiet = 5'h00;
		end else if (line_i != state.prev) begin
			next_state.active = 1'h1;
			next_state.quiet = 5'h00;
		end else if (state.active) begin
			next_state.quiet = state.quiet + 5'h01;
			if (next_state.quiet == `LINE_QUIET_CYCLES) begin
				next_state.active = 1'h0;
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign active_o = state.active;

endmodule

`default_nettype wire

// file: transceiver_status_flags.sv
`timescale 1ns/10ps
`default_nettype none
`include "xcvr_flags_params.svh"

module transceiver_status_flags (
	// clock and reset
	input  wire logic        CORE_CLK_I,
	input  wire logic        RST_I,
	// register bus, write channels
	input  wire logic [7:0]  AWADDR_I,
	input  wire logic        AWVALID_I,
	output logic             AWREADY_O,
	input  wire logic [31:0] WDATA_I,
	input  wire logic [3:0]  WSTRB_I,
	input  wire logic        WVALID_I,
	output logic             WREADY_O,
	output logic [1:0]       BRESP_O,
	output logic             BVALID_O,
	input  wire logic        BREADY_I,
	// register bus, read channels
	input  wire logic [7:0]  ARADDR_I,
	input  wire logic        ARVALID_I,
	output logic             ARREADY_O,
	output logic [31:0]      RDATA_O,
	output logic [1:0]       RRESP_O,
	output logic             RVALID_O,
	input  wire logic        RREADY_I,
	// serial line inputs
	input  wire logic        DATA_IN_I,
	input  wire logic        ANALOG_RX_I,
	// transmitter state
	input  wire logic        TX_ACTIVE_I,
	input  wire logic        TX_FIFO_EMPTY_I,
	input  wire logic        TX_FIFO_FULL_I,
	// receiver events as one-cycle pulses, plus the station address
	input  wire logic        RX_WORD_VALID_I,
	input  wire logic        RX_ERROR_I,
	input  wire logic        START_SEQ_I,
	input  wire logic        END_MSG_I,
	input  wire logic        POLL_CMD_I,
	input  wire logic        POLL_ACK_CMD_I,
	input  wire logic        AUTO_RESP_CMD_I,
	input  wire logic        BYTE_PARITY_ERR_I,
	input  wire logic        ADDR_DECODED_I,
	input  wire logic [2:0]  STATION_ADDR_I,
	// receiver data path
	input  wire logic [1:0]  RX_FIFO_COUNT_I,
	input  wire logic [2:0]  RX_TOP_BITS_I,
	input  wire logic [7:0]  RX_DATA_I,
	input  wire logic [4:0]  ERR_CODE_I,
	// transceiver side outputs
	output logic             RX_SERIAL_O,
	output logic             TX_WRITE_O,
	output logic [7:0]       TX_WDATA_O,
	output logic             RX_READ_O,
	output logic             ECR_READ_O,
	output logic             XCVR_RESET_O,
	output logic             LOOPBACK_O
);

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		xcvr_flags_pkg::wr_state_type   wstate;
		logic                           aw_got;
		logic                           w_got;
		logic [7:0]                     waddr;
		logic [7:0]                     wdata;
		logic                           wlane0;
		logic                           awready;
		logic                           wready;
		logic                           bvalid;
		logic [1:0]                     bresp;
		logic                           arready;
		logic                           rvalid;
		logic [31:0]                    rdata;
		logic [1:0]                     rresp;
		logic                           src_sel;
		logic                           soft_rst;
		xcvr_flags_pkg::proto_mode_type mode;
		logic                           loopback;
		logic                           first_done;
		logic                           rx_serial;
		logic                           tx_busy;
		logic                           tx_full;
		logic                           tx_empty;
		logic                           wr_recent;
		logic                           rxq3_prev;
		logic                           tx_write;
		logic [7:0]                     tx_wdata;
		logic                           rx_read;
		logic                           ecr_read;
	} main_state_type;

	main_state_type state;
	main_state_type next_state;

	logic [`FLG_COUNT-1:0] flags;
	logic [`FLG_COUNT-1:0] set_vec;
	logic [`FLG_COUNT-1:0] clr_vec;
	logic                  line_active;
	logic                  data_read;
	logic                  data_write;
	logic                  ecr_rd;
	logic                  turn_w1c;
	logic [7:0]            line_flag_val;
	logic [7:0]            status_val;

	// ****************************************************************
	// flag bank
	// ****************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < `FLG_COUNT; gi = gi + 1) begin : g_flag
			flag_cell u_flag (
				.clk_i      (CORE_CLK_I),
				.rst_i      (RST_I),
				.soft_rst_i (state.soft_rst),
				.set_i      (set_vec[gi]),
				.clr_i      (clr_vec[gi]),
				.flag_o     (flags[gi])
			);
		end
	endgenerate

	line_activity_detect u_activity (
		.clk_i      (CORE_CLK_I),
		.rst_i      (RST_I),
		.soft_rst_i (state.soft_rst),
		.line_i     (state.rx_serial),
		.active_o   (line_active)
	);

	// ****************************************************************
	// flag set and clear terms
	// ****************************************************************
	logic coax;
	logic first_frame;
	logic dav_now;

	always_comb begin
		coax = (state.mode == xcvr_flags_pkg::MODE_COAX);
		// the repeater's first frame leaves the byte error flag undefined; keep it low
		first_frame = (state.mode == xcvr_flags_pkg::MODE_REPEATER) && !state.first_done;
		dav_now = flags[`FLG_WORD_READY] | RX_WORD_VALID_I;
		set_vec = '0;
		clr_vec = '0;
		set_vec[`FLG_POLL] = coax & POLL_CMD_I & dav_now;
		set_vec[`FLG_POLL_ACK] = coax & POLL_ACK_CMD_I & dav_now;
		set_vec[`FLG_AUTO_RESP] = coax & AUTO_RESP_CMD_I & dav_now;
		set_vec[`FLG_BYTE_ERR] = ((coax | ((state.mode == xcvr_flags_pkg::MODE_REPEATER) & !first_frame))
			& BYTE_PARITY_ERR_I)
			| ((state.mode == xcvr_flags_pkg::MODE_TWINAX) & ADDR_DECODED_I
			& (STATION_ADDR_I == `ALL_STATIONS_ADDR) & dav_now);
		set_vec[`FLG_TURNAROUND] = END_MSG_I;
		set_vec[`FLG_RX_FULL] = (RX_FIFO_COUNT_I == `RX_QUEUE_FULL_WORDS) & !state.rxq3_prev;
		set_vec[`FLG_WORD_READY] = RX_WORD_VALID_I;
		set_vec[`FLG_IN_FRAME] = START_SEQ_I;
		set_vec[`FLG_RX_FAULT] = RX_ERROR_I;
		clr_vec[`FLG_POLL] = data_read;
		clr_vec[`FLG_POLL_ACK] = data_read;
		clr_vec[`FLG_AUTO_RESP] = data_read;
		clr_vec[`FLG_BYTE_ERR] = data_read;
		clr_vec[`FLG_TURNAROUND] = data_write | turn_w1c;
		clr_vec[`FLG_RX_FULL] = data_read;
		clr_vec[`FLG_WORD_READY] = data_read | RX_ERROR_I;
		clr_vec[`FLG_IN_FRAME] = END_MSG_I | RX_ERROR_I;
		clr_vec[`FLG_RX_FAULT] = ecr_rd;
	end

	always_comb begin
		line_flag_val = {state.tx_empty, flags[`FLG_RX_FULL], line_active, flags[`FLG_TURNAROUND],
			flags[`FLG_BYTE_ERR], flags[`FLG_AUTO_RESP], flags[`FLG_POLL_ACK], flags[`FLG_POLL]};
		status_val = {state.tx_full, state.tx_busy, flags[`FLG_RX_FAULT], flags[`FLG_IN_FRAME],
			flags[`FLG_WORD_READY], RX_TOP_BITS_I};
	end

	// ****************************************************************
	// bus slave and transceiver control
	// ****************************************************************
	logic       wr_fire;
	logic [7:0] wa;
	logic [7:0] wd;
	logic       wl0;
	logic       rd_fire;

	always_comb begin
		next_state = state;
		data_read = 1'h0;
		data_write = 1'h0;
		ecr_rd = 1'h0;
		turn_w1c = 1'h0;
		wr_fire = 1'h0;
		rd_fire = ARVALID_I & state.arready;
		wa = state.aw_got ? state.waddr : AWADDR_I;
		wd = state.w_got ? state.wdata : WDATA_I[7:0];
		wl0 = state.w_got ? state.wlane0 : WSTRB_I[0];
		next_state.tx_write = 1'h0;
		next_state.rx_read = 1'h0;
		next_state.ecr_read = 1'h0;

		case (state.wstate)
			xcvr_flags_pkg::WR_COLLECT: begin
				if (AWVALID_I && state.awready) begin
					next_state.aw_got = 1'h1;
					next_state.waddr = AWADDR_I;
					next_state.awready = 1'h0;
				end
				if (WVALID_I && state.wready) begin
					next_state.w_got = 1'h1;
					next_state.wdata = WDATA_I[7:0];
					next_state.wlane0 = WSTRB_I[0];
					next_state.wready = 1'h0;
				end
				if (next_state.aw_got && next_state.w_got) begin
					wr_fire = 1'h1;
					next_state.bvalid = 1'h1;
					next_state.bresp = `RESP_OKAY;
					next_state.wstate = xcvr_flags_pkg::WR_RESPOND;
				end
			end
			xcvr_flags_pkg::WR_RESPOND: begin
				if (BREADY_I) begin
					next_state.bvalid = 1'h0;
					next_state.aw_got = 1'h0;
					next_state.w_got = 1'h0;
					next_state.awready = 1'h1;
					next_state.wready = 1'h1;
					next_state.wstate = xcvr_flags_pkg::WR_COLLECT;
				end
			end
			default: begin
				next_state.wstate = xcvr_flags_pkg::WR_COLLECT;
			end
		endcase

		if (wr_fire) begin
			case (wa)
				`OFS_LINE_FLAG: begin
					turn_w1c = wl0 & wd[`BIT_TURNAROUND];
				end
				`OFS_XCVR_STATUS: begin
				end
				`OFS_XCVR_CONTROL: begin
					if (wl0) begin
						next_state.src_sel = wd[`BIT_RX_SOURCE_SELECT];
					end
				end
				`OFS_XCVR_MODE: begin
					if (wl0) begin
						next_state.soft_rst = wd[`BIT_SOFT_RESET];
					end
				end
				`OFS_RX_TX_DATA: begin
					if (wl0) begin
						data_write = 1'h1;
						next_state.tx_write = 1'h1;
						next_state.tx_wdata = wd;
					end
				end
				`OFS_ERROR_CODE: begin
				end
				`OFS_PROTO_CONFIG: begin
					if (wl0) begin
						next_state.mode = xcvr_flags_pkg::proto_mode_type'(wd[1:0]);
						next_state.loopback = wd[`BIT_LOOPBACK];
					end
				end
				default: begin
					next_state.bresp = `RESP_SLVERR;
				end
			endcase
		end

		// read side: one read in flight, data captured at the address handshake
		if (rd_fire) begin
			next_state.arready = 1'h0;
			next_state.rvalid = 1'h1;
			next_state.rresp = `RESP_OKAY;
			next_state.rdata = 32'h0000_0000;
			case (ARADDR_I)
				`OFS_LINE_FLAG: next_state.rdata[7:0] = line_flag_val;
				`OFS_XCVR_STATUS: next_state.rdata[7:0] = status_val;
				`OFS_XCVR_CONTROL: next_state.rdata[`BIT_RX_SOURCE_SELECT] = state.src_sel;
				`OFS_XCVR_MODE: next_state.rdata[`BIT_SOFT_RESET] = state.soft_rst;
				`OFS_RX_TX_DATA: begin
					next_state.rdata[7:0] = RX_DATA_I;
					data_read = 1'h1;
					next_state.rx_read = 1'h1;
				end
				`OFS_ERROR_CODE: begin
					next_state.rdata[4:0] = ERR_CODE_I;
					ecr_rd = 1'h1;
					next_state.ecr_read = 1'h1;
				end
				`OFS_PROTO_CONFIG: next_state.rdata[2:0] = {state.loopback, state.mode};
				default: next_state.rresp = `RESP_SLVERR;
			endcase
		end else if (state.rvalid && RREADY_I) begin
			next_state.rvalid = 1'h0;
			next_state.arready = 1'h1;
		end

		// transceiver-facing status sampling
		next_state.rx_serial = state.src_sel ? ANALOG_RX_I : DATA_IN_I;
		next_state.tx_busy = TX_ACTIVE_I;
		next_state.tx_full = TX_FIFO_FULL_I;
		next_state.rxq3_prev = (RX_FIFO_COUNT_I == `RX_QUEUE_FULL_WORDS);
		// the FIFO's own empty indication lags a write by a cycle; mask it meanwhile
		next_state.wr_recent = data_write;
		next_state.tx_empty = TX_FIFO_EMPTY_I & !data_write & !state.wr_recent;
		if (state.soft_rst) begin
			next_state.first_done = 1'h0;
			next_state.tx_empty = `RST_TX_QUEUE_EMPTY;
		end else if (END_MSG_I && (state.mode == xcvr_flags_pkg::MODE_REPEATER)) begin
			next_state.first_done = 1'h1;
		end
	end

	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			state <= '0;
			state.awready <= 1'h1;
			state.wready <= 1'h1;
			state.arready <= 1'h1;
			state.tx_empty <= `RST_TX_QUEUE_EMPTY;
		end else begin
			state <= next_state;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign AWREADY_O = state.awready;
	assign WREADY_O = state.wready;
	assign BRESP_O = state.bresp;
	assign BVALID_O = state.bvalid;
	assign ARREADY_O = state.arready;
	assign RDATA_O = state.rdata;
	assign RRESP_O = state.rresp;
	assign RVALID_O = state.rvalid;
	assign RX_SERIAL_O = state.rx_serial;
	assign TX_WRITE_O = state.tx_write;
	assign TX_WDATA_O = state.tx_wdata;
	assign RX_READ_O = state.rx_read;
	assign ECR_READ_O = state.ecr_read;
	assign XCVR_RESET_O = state.soft_rst;
	assign LOOPBACK_O = state.loopback;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (RST_I);

	a_source_select: assert property (
		##1 (RX_SERIAL_O == ($past(state.src_sel) ? $past(ANALOG_RX_I) : $past(DATA_IN_I))))
		else $error("receiver source does not follow select bit");
	a_busy_follows: assert property (
		state.loopback && TX_ACTIVE_I |=> status_val[6])
		else $error("busy status lost under loopback");
	a_empty_write: assert property (
		data_write && !state.soft_rst |=> !state.tx_empty ##1 !state.tx_empty)
		else $error("queue empty flag not cleared by data write");
	a_full_mirror: assert property (
		TX_FIFO_FULL_I |=> status_val[7])
		else $error("queue full flag missing");
	a_poll_ack_set: assert property (
		coax && POLL_ACK_CMD_I && flags[`FLG_WORD_READY] && !state.soft_rst |=> flags[`FLG_POLL_ACK])
		else $error("poll ack flag not set");
	a_word_ready: assert property (
		RX_ERROR_I && !RX_WORD_VALID_I |=> !flags[`FLG_WORD_READY])
		else $error("data available survives an error");
	a_station_all: assert property (
		state.mode == xcvr_flags_pkg::MODE_TWINAX && ADDR_DECODED_I && STATION_ADDR_I == 3'h7
		&& flags[`FLG_WORD_READY] && !state.soft_rst |=> flags[`FLG_BYTE_ERR])
		else $error("all-station address not flagged");
	a_line_edge: assert property (
		$changed(state.rx_serial) && !state.soft_rst |=> line_active [*8])
		else $error("line activity dropped too early");
	a_turn_clear: assert property (
		turn_w1c && !END_MSG_I |=> !flags[`FLG_TURNAROUND])
		else $error("turnaround not cleared by write of one");
	a_in_frame: assert property (
		START_SEQ_I && !state.soft_rst |=> flags[`FLG_IN_FRAME])
		else $error("in-frame flag not set on start");
	a_fault_hold: assert property (
		flags[`FLG_RX_FAULT] && !ecr_rd && !state.soft_rst |=> flags[`FLG_RX_FAULT])
		else $error("receiver fault cleared without error code read");
	a_soft_clear: assert property (
		state.soft_rst |=> (flags == '0) && state.tx_empty && !line_active)
		else $error("soft reset left a flag in the wrong state");

endmodule

`default_nettype wire

// file: remote_station.sv
`timescale 1ns/10ps
`default_nettype none

module remote_station (
	// clock
	input  wire logic       clk_i,
	// frame request, command mask: auto, ack, poll
	input  wire logic       go_i,
	input  wire logic [2:0] cmd_i,
	// line and decoded events
	output logic            line_o,
	output logic            start_o,
	output logic            word_o,
	output logic [2:0]      cmd_o
);
	// ****
	// frame sequencer
	// ****
	// the line stands still between frames so only a frame shows activity
	logic [3:0] step;
	initial begin
		line_o = 1'b0;
		step = 4'h0;
		start_o = 1'b0;
		word_o = 1'b0;
		cmd_o = 3'h0;
	end
	always @(posedge clk_i) begin
		if (go_i) step <= 4'h1;
		else if (step != 4'h0) step <= step + 4'h1;
		if (step == 4'h8) step <= 4'h0;
		if (step >= 4'h1 && step <= 4'h4) line_o <= ~line_o;
		start_o <= (step == 4'h5);
		word_o <= (step == 4'h6);
		// command comes one cycle after the word so data available is already set
		cmd_o <= (step == 4'h7) ? cmd_i : 3'h0;
	end
endmodule

`default_nettype wire

// file: testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "xcvr_flags_params.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; $display("wrong value %s exp %h got %h", n, e, g); end end

module testbench;
	typedef struct packed {logic [7:0] a; logic [31:0] d; logic [1:0] r;} row_type;
	logic        clk, rst, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
	logic [7:0]  awaddr, araddr, tx_wdata;
	logic [31:0] wdata, rdata, rd_d;
	logic [1:0]  bresp, rresp, rd_r, wr_r, fifo_cnt;
	logic        analog, tx_active_out, tx_empty, tx_full, go, line, start_seq, word;
	logic [3:0]  ev;
	logic [2:0]  station, cmd, ev_cmd;
	logic        rx_serial, tx_write, rx_read, ecr_read, xcvr_reset, loopback;
	int          num_errors, checked, cycles, i, n_txw, n_rxr, n_ecr;
	row_type     rows [0:7];

	transceiver_status_flags dut_u (.CORE_CLK_I(clk), .RST_I(rst),
		.AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(4'hF),
		.WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
		.ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata), .RRESP_O(rresp),
		.RVALID_O(rvalid), .RREADY_I(rready), .DATA_IN_I(line), .ANALOG_RX_I(analog),
		.TX_ACTIVE_I(tx_active_out), .TX_FIFO_EMPTY_I(tx_empty), .TX_FIFO_FULL_I(tx_full),
		.RX_WORD_VALID_I(word), .RX_ERROR_I(ev[0]), .START_SEQ_I(start_seq), .END_MSG_I(ev[1]),
		.POLL_CMD_I(ev_cmd[0]), .POLL_ACK_CMD_I(ev_cmd[1]), .AUTO_RESP_CMD_I(ev_cmd[2]),
		.BYTE_PARITY_ERR_I(ev[3]), .ADDR_DECODED_I(ev[2]), .STATION_ADDR_I(station),
		.RX_FIFO_COUNT_I(fifo_cnt), .RX_TOP_BITS_I(3'h5), .RX_DATA_I(8'h5A), .ERR_CODE_I(5'h0B),
		.RX_SERIAL_O(rx_serial), .TX_WRITE_O(tx_write), .TX_WDATA_O(tx_wdata), .RX_READ_O(rx_read),
		.ECR_READ_O(ecr_read), .XCVR_RESET_O(xcvr_reset), .LOOPBACK_O(loopback));
	remote_station partner_u (.clk_i(clk), .go_i(go), .cmd_i(cmd), .line_o(line), .start_o(start_seq),
		.word_o(word), .cmd_o(ev_cmd));

	// ****
	// bus and event tasks
	// ****
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic at, wt, bt;
		@(posedge clk);
		awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		do begin
			@(negedge clk);
			at = awvalid && awready; wt = wvalid && wready; bt = bvalid;
			wr_r = bresp;
			@(posedge clk);
			if (at) awvalid <= 1'b0;
			if (wt) wvalid <= 1'b0;
		end while (!bt);
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		logic at, rt;
		@(posedge clk);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		do begin
			@(negedge clk);
			at = arvalid && arready; rt = rvalid; rd_d = rdata; rd_r = rresp;
			@(posedge clk);
			if (at) arvalid <= 1'b0;
		end while (!rt);
		rready <= 1'b0;
	endtask
	task automatic pulse(input logic [3:0] m);
		@(posedge clk); ev <= m;
		@(posedge clk); ev <= 4'h0;
	endtask
	task automatic frame(input logic [2:0] c);
		@(posedge clk); cmd <= c; go <= 1'b1;
		@(posedge clk); go <= 1'b0;
		repeat (10) @(posedge clk);
	endtask
	task finish_test;
		if (num_errors == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// whole run is well under a thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (tx_write) n_txw++;
		if (rx_read) n_rxr++;
		if (ecr_read) n_ecr++;
		if (cycles == 5000) begin num_errors++; finish_test(); end
	end

	initial begin
		rst = 1'b1; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0; awaddr = 0; araddr = 0;
		wdata = 0; analog = 0; tx_active_out = 0; tx_empty = 1; tx_full = 0; go = 0; ev = 0; station = 0;
		cmd = 0; fifo_cnt = 0; num_errors = 0; checked = 0; cycles = 0; n_txw = 0; n_rxr = 0; n_ecr = 0;
		rows[0] = '{`OFS_LINE_FLAG, 32'h80, `RESP_OKAY}; rows[1] = '{`OFS_XCVR_STATUS, 32'h05, `RESP_OKAY};
		rows[2] = '{`OFS_XCVR_CONTROL, 32'h0, `RESP_OKAY}; rows[3] = '{`OFS_XCVR_MODE, 32'h0, `RESP_OKAY};
		rows[4] = '{`OFS_PROTO_CONFIG, 32'h0, `RESP_OKAY}; rows[5] = '{8'h1C, 32'h0, `RESP_SLVERR};
		rows[6] = '{`OFS_ERROR_CODE, 32'h0B, `RESP_OKAY}; rows[7] = '{`OFS_RX_TX_DATA, 32'h5A, `RESP_OKAY};
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		for (i = 0; i < 8; i++) begin
			rd(rows[i].a);
			`CHK("reg data", rows[i].d, rd_d)
			`CHK("reg resp", rows[i].r, rd_r)
		end
		analog <= 1'b1;
		repeat (2) @(posedge clk);
		`CHK("rx serial", 1'b0, rx_serial)
		wr(`OFS_XCVR_CONTROL, 32'h20);
		repeat (2) @(posedge clk);
		`CHK("rx serial", 1'b1, rx_serial)
		wr(`OFS_XCVR_CONTROL, 32'h0);
		repeat (20) @(posedge clk);
		rd(`OFS_LINE_FLAG);
		`CHK("quiet line", 32'h80, rd_d)
		frame(3'b111);
		rd(`OFS_LINE_FLAG);
		`CHK("cmd flags", 32'hA7, rd_d)
		rd(`OFS_XCVR_STATUS);
		`CHK("frame status", 32'h1D, rd_d)
		rd(`OFS_RX_TX_DATA);
		repeat (20) @(posedge clk);
		rd(`OFS_LINE_FLAG);
		`CHK("read clears", 32'h80, rd_d)
		rd(`OFS_XCVR_STATUS);
		`CHK("no data", 32'h15, rd_d)
		fifo_cnt <= 2'h3;
		rd(`OFS_LINE_FLAG);
		`CHK("rx full", 1'b1, rd_d[6])
		rd(`OFS_RX_TX_DATA);
		rd(`OFS_LINE_FLAG);
		`CHK("rx full", 1'b0, rd_d[6])
		fifo_cnt <= 2'h0;
		pulse(4'b1000);
		rd(`OFS_LINE_FLAG);
		`CHK("parity", 1'b1, rd_d[3])
		pulse(4'b0010);
		rd(`OFS_XCVR_STATUS);
		`CHK("end frame", 1'b0, rd_d[4])
		// byte error stays up until the next data read
		rd(`OFS_LINE_FLAG);
		`CHK("turnaround", 32'h98, rd_d)
		wr(`OFS_LINE_FLAG, 32'h10);
		`CHK("wr resp", `RESP_OKAY, wr_r)
		rd(`OFS_LINE_FLAG);
		`CHK("w1c", 1'b0, rd_d[4])
		pulse(4'b0010);
		tx_empty <= 1'b0;
		wr(`OFS_RX_TX_DATA, 32'h33);
		`CHK("tx data", 8'h33, tx_wdata)
		rd(`OFS_LINE_FLAG);
		`CHK("data write", 32'h08, rd_d)
		tx_empty <= 1'b1;
		frame(3'b000);
		pulse(4'b0001);
		rd(`OFS_XCVR_STATUS);
		`CHK("fault", 32'h25, rd_d)
		rd(`OFS_RX_TX_DATA);
		rd(`OFS_XCVR_STATUS);
		`CHK("fault held", 1'b1, rd_d[5])
		rd(`OFS_ERROR_CODE);
		rd(`OFS_XCVR_STATUS);
		`CHK("fault clr", 1'b0, rd_d[5])
		wr(`OFS_PROTO_CONFIG, 32'h2);
		frame(3'b000);
		station <= 3'h7;
		pulse(4'b0100);
		rd(`OFS_LINE_FLAG);
		`CHK("all stations", 1'b1, rd_d[3])
		rd(`OFS_RX_TX_DATA);
		wr(`OFS_PROTO_CONFIG, 32'h4);
		tx_active_out <= 1'b1;
		tx_full <= 1'b1;
		rd(`OFS_XCVR_STATUS);
		`CHK("tx busy full", 2'b11, rd_d[7:6])
		`CHK("loopback", 1'b1, loopback)
		tx_active_out <= 1'b0;
		tx_full <= 1'b0;
		// repeater: parity is ignored until its first frame has ended
		wr(`OFS_PROTO_CONFIG, 32'h1);
		pulse(4'b1000);
		rd(`OFS_LINE_FLAG);
		`CHK("first frame", 1'b0, rd_d[3])
		pulse(4'b0010);
		pulse(4'b1000);
		rd(`OFS_LINE_FLAG);
		`CHK("repeater parity", 1'b1, rd_d[3])
		rd(`OFS_RX_TX_DATA);
		wr(`OFS_PROTO_CONFIG, 32'h3);
		frame(3'b111);
		rd(`OFS_LINE_FLAG);
		`CHK("octet cmds", 3'h0, rd_d[2:0])
		rd(`OFS_RX_TX_DATA);
		wr(8'h1C, 32'h0);
		`CHK("wr resp", `RESP_SLVERR, wr_r)
		wr(`OFS_PROTO_CONFIG, 32'h0);
		frame(3'b111);
		pulse(4'b0011);
		wr(`OFS_XCVR_MODE, 32'h80);
		repeat (2) @(posedge clk);
		`CHK("soft reset", 1'b1, xcvr_reset)
		rd(`OFS_LINE_FLAG);
		`CHK("soft flags", 32'h80, rd_d)
		rd(`OFS_XCVR_STATUS);
		`CHK("soft status", 32'h05, rd_d)
		rd(`OFS_XCVR_MODE);
		`CHK("mode bit", 32'h80, rd_d)
		`CHK("data writes", 1, n_txw)
		`CHK("data reads", 7, n_rxr)
		`CHK("ecr reads", 2, n_ecr)
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(`OFS_XCVR_MODE);
		`CHK("mode after rst", 32'h0, rd_d)
		`CHK("xcvr reset", 1'b0, xcvr_reset)
		finish_test();
	end
endmodule

`default_nettype wire
